//--- core/pesf_pkg.sv
/*
  shared constants for the phy event status flags block: flag order,
  counter width, reset values.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package pesf_pkg;
  localparam int NUM_FLAGS = 5;
  localparam int CNT_W = 16;
  localparam int CNT_MSB = CNT_W - 1;
  // flag bit positions in the status word
  localparam int FLAG_SPEED = 0;
  localparam int FLAG_DUPLEX = 1;
  localparam int FLAG_ANEG = 2;
  localparam int FLAG_FCHALF = 3;
  localparam int FLAG_REHALF = 4;
  // register locations of the two event counters
  localparam logic [15:0] FALSE_CARRIER_EVENT_COUNTER_ADDR = 16'h0014;
  localparam logic [15:0] RECEIVE_ERROR_EVENT_COUNTER_ADDR = 16'h0015;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 5'h0_0;
  localparam logic [NUM_FLAGS-1:0] ENABLE_RESET = 5'h0_0;
  localparam logic RESOLVED_RESET = 1'b0;
  localparam logic ANEG_RESET = 1'b0;
endpackage : pesf_pkg
`default_nettype wire

//--- core/pesf_flag.sv
/*
  one clear-on-read sticky pending flag.
  assumes event and read strobe come from logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pesf_flag (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // event and clear
  input wire logic setEvent,
  input wire logic readClear,
  // state
  output logic pending
);
  import pesf_pkg::*;
  logic next_pending;

  // set wins over a read in the same cycle
  always_comb begin
    next_pending = pending;
    if (readClear) begin
      next_pending = 1'b0;
    end
    if (setEvent) begin
      next_pending = 1'b1;
    end
  end

  // register the flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end
endmodule // pesf_flag
`default_nettype wire

//--- core/pesf_phy_event_status_flags.sv
/*
  pending flags for speed, duplex, negotiation-complete and counter
  half-full events, cleared by a host read, gated onto an interrupt.
  assumes all inputs come from phy core logic on mclk, and that the
  host read strobe is one pulse per status register read.
  no synchroniser: every source already runs on mclk.
*/
// How it works
// - speed status change sets speed flag
// - duplex status change sets duplex flag
// - negotiation finishing sets completion flag
// - false-carrier counter past half sets flag
// - receive-error counter past half sets flag
// - flags reset zero, clear on host read
// - interrupt only for enabled events; enables reset
`timescale 1ns/1ps
`default_nettype none
module pesf_phy_event_status_flags (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // event sources
  input wire logic resolvedSpeed,
  input wire logic resolvedDuplex,
  input wire logic anegComplete,
  input wire logic [pesf_pkg::CNT_W-1:0] falseCarrierEventCounter,
  input wire logic [pesf_pkg::CNT_W-1:0] receiveErrorEventCounter,
  // host access
  input wire logic statusRead,
  input wire logic [pesf_pkg::NUM_FLAGS-1:0] enableWrData,
  input wire logic enableWrite,
  // status and interrupt
  output logic [pesf_pkg::NUM_FLAGS-1:0] pendingFlags,
  output logic [pesf_pkg::NUM_FLAGS-1:0] enableBits,
  output logic irq
);
  import pesf_pkg::*;

  // history registers, one per source
  logic primed;
  logic speedLast;
  logic duplexLast;
  logic anegLast;
  logic fcMsbLast;
  logic reMsbLast;
  // next values of the history
  logic next_primed;
  logic next_speedLast;
  logic next_duplexLast;
  logic next_anegLast;
  logic next_fcMsbLast;
  logic next_reMsbLast;
  // counter top bits, the half-full level
  logic fcMsb;
  logic reMsb;
  // one strobe per source, one cycle wide
  logic speedEvent;
  logic duplexEvent;
  logic anegEvent;
  logic fcHalfEvent;
  logic reHalfEvent;
  logic [NUM_FLAGS-1:0] events;
  // enables, interrupt and their next values
  logic [NUM_FLAGS-1:0] next_enableBits;
  logic [NUM_FLAGS-1:0] irqSources;
  logic next_irq;

  // primed rises on the first edge after reset and stays
  always_comb begin
    next_primed = 1'b1;
  end

  // register the primed marker
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      primed <= 1'b0;
    end else begin
      primed <= next_primed;
    end
  end

  // speed history follows the resolved level every cycle
  always_comb begin
    next_speedLast = resolvedSpeed;
  end

  // register the speed history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      speedLast <= RESOLVED_RESET;
    end else begin
      speedLast <= next_speedLast;
    end
  end

  // any speed level change is an event once primed
  assign speedEvent = primed && (resolvedSpeed != speedLast);

  // duplex history follows the resolved level every cycle
  always_comb begin
    next_duplexLast = resolvedDuplex;
  end

  // register the duplex history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      duplexLast <= RESOLVED_RESET;
    end else begin
      duplexLast <= next_duplexLast;
    end
  end

  // any duplex level change is an event once primed
  assign duplexEvent = primed && (resolvedDuplex != duplexLast);

  // negotiation history follows the completion level
  always_comb begin
    next_anegLast = anegComplete;
  end

  // register the negotiation history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      anegLast <= ANEG_RESET;
    end else begin
      anegLast <= next_anegLast;
    end
  end

  // only the rising completion level counts; falling is ignored
  assign anegEvent = anegComplete && !anegLast;

  // top bit of the false-carrier counter marks half-full
  assign fcMsb = falseCarrierEventCounter[CNT_MSB];

  // false-carrier history follows the top bit
  always_comb begin
    next_fcMsbLast = fcMsb;
  end

  // register the false-carrier history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fcMsbLast <= 1'b0;
    end else begin
      fcMsbLast <= next_fcMsbLast;
    end
  end

  // rising top bit only; no repeat while above half
  assign fcHalfEvent = fcMsb && !fcMsbLast;

  // top bit of the receive-error counter marks half-full
  assign reMsb = receiveErrorEventCounter[CNT_MSB];

  // receive-error history follows the top bit
  always_comb begin
    next_reMsbLast = reMsb;
  end

  // register the receive-error history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reMsbLast <= 1'b0;
    end else begin
      reMsbLast <= next_reMsbLast;
    end
  end

  // rising top bit only; no repeat while above half
  assign reHalfEvent = reMsb && !reMsbLast;

  // gather the strobes in status-word order
  always_comb begin
    events = '0;
    events[FLAG_SPEED] = speedEvent;
    events[FLAG_DUPLEX] = duplexEvent;
    events[FLAG_ANEG] = anegEvent;
    events[FLAG_FCHALF] = fcHalfEvent;
    events[FLAG_REHALF] = reHalfEvent;
  end

  // one sticky clear-on-read flag per event
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      pesf_flag u_flag (
        .mclk(mclk),
        .rst_n(rst_n),
        .setEvent(events[gi]),
        .readClear(statusRead),
        .pending(pendingFlags[gi])
      );
    end
  endgenerate

  // enable bits load on a write pulse, hold otherwise
  always_comb begin
    next_enableBits = enableBits;
    if (enableWrite) begin
      next_enableBits = enableWrData;
    end
  end

  // register the enables
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enableBits <= ENABLE_RESET;
    end else begin
      enableBits <= next_enableBits;
    end
  end

  // only enabled pending flags reach the interrupt
  assign irqSources = pendingFlags & enableBits;

  // interrupt is any enabled pending flag
  always_comb begin
    next_irq = |irqSources;
  end

  // register the interrupt
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end
endmodule // pesf_phy_event_status_flags
`default_nettype wire

//--- verification/pesf_status_monitor.sv
/*
  concurrent checks on the status flags block.
  assumes it is bound to the block's top and sees its ports, all on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pesf_status_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // event sources
  input wire logic resolvedSpeed,
  input wire logic resolvedDuplex,
  input wire logic anegComplete,
  input wire logic [15:0] falseCarrierEventCounter,
  input wire logic [15:0] receiveErrorEventCounter,
  // host access
  input wire logic statusRead,
  input wire logic [4:0] enableWrData,
  input wire logic enableWrite,
  // status and interrupt
  input wire logic [4:0] pendingFlags,
  input wire logic [4:0] enableBits,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_speed_set: assert property ($changed(resolvedSpeed) && $past(rst_n)
    |=> pendingFlags[0]) else $error("speed flag missed");
  a_aneg_set: assert property ($rose(anegComplete) && $past(rst_n)
    |=> pendingFlags[2]) else $error("aneg flag missed");
  a_fc_half: assert property ($rose(falseCarrierEventCounter[15])
    && $past(rst_n) |=> pendingFlags[3]) else $error("fc flag missed");
  a_re_half: assert property ($rose(receiveErrorEventCounter[15])
    && $past(rst_n) |=> pendingFlags[4]) else $error("re flag missed");
  a_read_clear: assert property (statusRead && $stable(resolvedSpeed)
    |=> !pendingFlags[0]) else $error("read left flag");
  a_flag_sticky: assert property (!statusRead
    |=> (pendingFlags & $past(pendingFlags)) == $past(pendingFlags))
    else $error("flag dropped");
  a_irq_gate: assert property ((pendingFlags & enableBits) == 0
    |=> !irq) else $error("irq not gated");
  a_half_once: assert property (statusRead
    && $stable(falseCarrierEventCounter[15]) |=> !pendingFlags[3])
    else $error("fc flag re-set");
  a_duplex_set: assert property ($changed(resolvedDuplex)
    && $past(rst_n) |=> pendingFlags[1]) else $error("duplex flag missed");
  a_irq_raise: assert property ((pendingFlags & enableBits) != 0
    |=> irq) else $error("irq not raised");
  // a read with no coinciding source change
  sequence s_quiet_read;
    statusRead && $past(rst_n) && $stable(resolvedSpeed) &&
    $stable(resolvedDuplex) && !$rose(anegComplete) &&
    !$rose(falseCarrierEventCounter[15]) &&
    !$rose(receiveErrorEventCounter[15]);
  endsequence
  a_read_all: assert property (s_quiet_read
    |=> pendingFlags == 5'h0_0) else $error("read left flags");
endmodule // pesf_status_monitor
bind pesf_phy_event_status_flags pesf_status_monitor mon_u (.*);
`default_nettype wire

//--- verification/pesf_host_model.sv
/* host side: status read strobe; assumes caller runs at falling edge */
`timescale 1ns/1ps
`default_nettype none
module pesf_host_model (
  input wire logic mclk,
  output logic statusRead
);
  initial statusRead = 1'b0;
  // one-cycle whole-register read, then one idle cycle
  task automatic read;
    statusRead = 1'b1;
    @(negedge mclk);
    statusRead = 1'b0;
    @(negedge mclk);
  endtask
endmodule // pesf_host_model
`default_nettype wire

//--- verification/pesf_phy_event_status_flags_tb_top.sv
/* flags block testbench; assumes host model and monitor compiled first */
`timescale 1ns/1ps
`default_nettype none
module pesf_phy_event_status_flags_tb_top;
  logic mclk = 0, rst_n = 0, spd = 0, dup = 0, aneg = 0, enWr = 0, rd, irq;
  logic [15:0] fc = 0, re = 0;
  logic [4:0] en = 0, flags, enBits;
  int failures = 0, check_count = 0;
  always #4 mclk = ~mclk;
  pesf_phy_event_status_flags dut_u (.mclk(mclk), .rst_n(rst_n),
    .resolvedSpeed(spd), .resolvedDuplex(dup), .anegComplete(aneg),
    .falseCarrierEventCounter(fc), .receiveErrorEventCounter(re),
    .statusRead(rd), .enableWrData(en), .enableWrite(enWr),
    .pendingFlags(flags), .enableBits(enBits), .irq(irq));
  pesf_host_model host_u (.mclk(mclk), .statusRead(rd));
  task automatic chk(string n, logic [4:0] e, logic [4:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one event source per pass, read clears, msb held high
  initial begin
    repeat (16) @(negedge mclk);
    rst_n = 1;
    chk("flags", 5'h00, flags);
    chk("enables", 5'h00, enBits);
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: spd = ~spd;
        1: dup = ~dup;
        2: aneg = 1;
        3: fc = 16'h8000;
        default: re = 16'hFFFF;
      endcase
      @(negedge mclk);
      chk("set", 5'h01 << i, flags);
      @(negedge mclk);
      chk("held", 5'h01 << i, flags);
      chk("irq masked", 5'h00, {4'h0, irq});
      host_u.read();
      chk("cleared", 5'h00, flags);
      host_u.read();
      chk("no re-set", 5'h00, flags);
    end
    en = 5'h04;
    enWr = 1;
    @(negedge mclk);
    enWr = 0;
    chk("enables", 5'h04, enBits);
    spd = ~spd;
    repeat (2) @(negedge mclk);
    chk("other masked", 5'h00, {4'h0, irq});
    aneg = 0;
    @(negedge mclk);
    chk("aneg fall", 5'h01, flags);
    aneg = 1;
    repeat (2) @(negedge mclk);
    chk("irq", 5'h01, {4'h0, irq});
    // mid-run reset clears all; first edge after it only primes
    aneg = 0;
    fc = 16'h0000;
    re = 16'h0000;
    rst_n = 0;
    @(negedge mclk);
    chk("reset flags", 5'h00, flags);
    chk("reset enables", 5'h00, enBits);
    chk("reset irq", 5'h00, {4'h0, irq});
    rst_n = 1;
    spd = ~spd;
    repeat (2) @(negedge mclk);
    chk("primed", 5'h00, flags);
    dup = ~dup;
    @(negedge mclk);
    chk("duplex", 5'h02, flags);
    // event and read in one cycle: set wins
    spd = ~spd;
    host_u.read();
    chk("set wins", 5'h01, flags);
    final_report;
  end
endmodule // pesf_phy_event_status_flags_tb_top
`default_nettype wire
